// ==== core/cig_cpu_if.sv ====
// Processor-side interrupt interface: group-one enables, NMI acknowledge and priority mask.
`timescale 1ns/100ps

// Notes on behaviour
// - Bit 1 of the EL3 enable register enables Secure group-one interrupts.
// - Bit 0 of the EL3 enable register enables Non-secure group-one interrupts.
// - EL1 enable views alias the Secure and Non-secure bits; both views share storage.
// - Enable falling 1 to 0 retargets a pending one-of-N group-one interrupt elsewhere.
// - Reset clears both enable bits and the priority mask.
// - EL3 enable access undefined below EL3; traps class 0x18 when interface disabled.
// - NMI ack read returns the identifier in bits 23:0 and activates it.
// - Real identifier only when non-maskable, above mask and acknowledgeable here.
// - Otherwise the ack read returns a special reserved identifier.
// - Identifier is 16 or 24 bits, width reported; upper bits zero when 16.
// - Ack read is self-synchronizing; no spurious signal right after the read.
// - At EL1 the NMI ack access is undefined when the NMI feature is off.
// - At EL1 with EL2 on and IRQs routed to EL2, the virtual ack is returned.
// - Interrupt signalled only when its priority beats the 8-bit mask.
// - Mask writes take effect at once; nothing below the new mask is signalled.
// - Four to eight implemented priority bits; missing low bits read zero, ignore writes.
// - Low 32 bits of the mask register share storage with the 32-bit view.
module cig_cpu_if #(
    parameter int PRIO_BITS = 8,
    parameter int ID_BITS = 24
) (
    input wire logic CLOCK_IN,
    input wire logic RST_IN,
    input wire cig_pkg::cig_req_t REQ_IN,
    input wire cig_pkg::cig_ctl_t CTL_IN,
    input wire cig_pkg::cig_pend_t PEND_IN,
    input wire logic [23:0] VIRTUAL_NMI_ACK_GROUP1_IN,
    output logic DONE_OUT,
    output logic [63:0] RDATA_OUT,
    output logic UNDEF_OUT,
    output logic TRAP_OUT,
    output logic [1:0] TRAP_EL_OUT,
    output logic [5:0] SYNDROME_OUT,
    output logic ACK_OUT,
    output logic [23:0] ACK_ID_OUT,
    output logic RETARGET_OUT,
    output logic [23:0] RETARGET_ID_OUT,
    output logic IRQ_SIGNAL_OUT,
    output logic [2:0] ID_WIDTH_FIELD_OUT
);

    // Implemented priority bits sit at the top of the field; the rest are read-as-zero.
    localparam logic [7:0] PRIO_KEEP = 8'(9'h0FF << (8 - PRIO_BITS));
    localparam logic [23:0] ID_KEEP =
        (ID_BITS == 16) ? cig_pkg::CIG_ID_MASK_16 : cig_pkg::CIG_ID_MASK_24;
    localparam logic [2:0] ID_CODE =
        (ID_BITS == 16) ? cig_pkg::CIG_ID_WIDTH_16 : cig_pkg::CIG_ID_WIDTH_24;

    cig_pkg::cig_state_t st;
    cig_pkg::cig_state_t next_st;
    logic undef_c;
    logic trap_c;
    logic [1:0] trap_to;
    logic ack_ok;
    logic use_virtual;
    logic pend_en;

    // Access checks, evaluated in the order the core resolves them.
    always_comb begin
        undef_c = 1'b0;
        trap_c = 1'b0;
        trap_to = REQ_IN.el;
        case (REQ_IN.sel)
            cig_pkg::CIG_SEL_GRP1_EN_EL3: begin
                if (REQ_IN.el != cig_pkg::CIG_EL3) begin
                    undef_c = 1'b1;
                end else if (!CTL_IN.sysreg_if_enable_el3) begin
                    trap_c = 1'b1;
                end
            end
            cig_pkg::CIG_SEL_NMI_ACK_G1: begin
                if (REQ_IN.el == cig_pkg::CIG_EL0 || REQ_IN.write) begin
                    undef_c = 1'b1;
                end else if (!CTL_IN.nmi_feature_enable) begin
                    undef_c = 1'b1;
                end else if (!CTL_IN.sysreg_if_enable_cur) begin
                    trap_c = 1'b1;
                end
            end
            default: begin
                if (REQ_IN.el == cig_pkg::CIG_EL0) begin
                    undef_c = 1'b1;
                end else if (!CTL_IN.sysreg_if_enable_cur) begin
                    trap_c = 1'b1;
                end
            end
        endcase
    end

    // The pending interrupt's group enable, as seen with the current stored bits.
    assign pend_en = PEND_IN.secure ? st.secure_group1_enable : st.nonsecure_group1_enable;

    // An NMI is handed out only if every observability condition holds; EL3 may take both
    // security states, lower levels only their own.
    assign ack_ok = PEND_IN.valid && PEND_IN.nmi && PEND_IN.group1 && pend_en
        && (PEND_IN.prio < st.prio_mask)
        && (REQ_IN.el == cig_pkg::CIG_EL3 || PEND_IN.secure == REQ_IN.secure)
        && !(st.acked && PEND_IN.id == st.acked_id);
    assign use_virtual = (REQ_IN.el == cig_pkg::CIG_EL1) && CTL_IN.el2_enabled
        && CTL_IN.irq_route_to_hyp;

    // Next state: access handling, retargeting, ack tracking and signalling.
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.rdata = 64'h0;
        next_st.undef = 1'b0;
        next_st.trap = 1'b0;
        next_st.trap_el = 2'h0;
        next_st.syndrome = 6'h00;
        next_st.ack = 1'b0;
        next_st.retarget = 1'b0;
        if (!PEND_IN.valid || PEND_IN.id != st.acked_id) begin
            next_st.acked = 1'b0;
        end
        if (REQ_IN.valid) begin
            next_st.done = 1'b1;
            if (undef_c) begin
                next_st.undef = 1'b1;
            end else if (trap_c) begin
                next_st.trap = 1'b1;
                next_st.trap_el = trap_to;
                next_st.syndrome = cig_pkg::CIG_TRAP_SYNDROME;
            end else begin
                case (REQ_IN.sel)
                    cig_pkg::CIG_SEL_GRP1_EN_EL3: begin
                        if (REQ_IN.write) begin
                            next_st.secure_group1_enable =
                                REQ_IN.wdata[cig_pkg::CIG_GRP1_S_BIT];
                            next_st.nonsecure_group1_enable =
                                REQ_IN.wdata[cig_pkg::CIG_GRP1_NS_BIT];
                        end else begin
                            next_st.rdata[cig_pkg::CIG_GRP1_S_BIT] = st.secure_group1_enable;
                            next_st.rdata[cig_pkg::CIG_GRP1_NS_BIT] =
                                st.nonsecure_group1_enable;
                        end
                    end
                    cig_pkg::CIG_SEL_GRP1_EN_EL1: begin
                        // The banked view picks its bit from the access's security state.
                        if (REQ_IN.write && REQ_IN.secure) begin
                            next_st.secure_group1_enable = REQ_IN.wdata[0];
                        end else if (REQ_IN.write) begin
                            next_st.nonsecure_group1_enable = REQ_IN.wdata[0];
                        end else begin
                            next_st.rdata[0] = REQ_IN.secure ? st.secure_group1_enable
                                : st.nonsecure_group1_enable;
                        end
                    end
                    cig_pkg::CIG_SEL_NMI_ACK_G1: begin
                        if (use_virtual) begin
                            next_st.rdata[23:0] = VIRTUAL_NMI_ACK_GROUP1_IN & ID_KEEP;
                        end else if (ack_ok) begin
                            next_st.rdata[23:0] = PEND_IN.id & ID_KEEP;
                            next_st.ack = 1'b1;
                            next_st.ack_id = PEND_IN.id & ID_KEEP;
                            next_st.acked = 1'b1;
                            next_st.acked_id = PEND_IN.id;
                        end else begin
                            next_st.rdata[23:0] = cig_pkg::CIG_SPURIOUS_ID;
                        end
                    end
                    default: begin
                        // Both widths of the mask view share one byte of storage.
                        if (REQ_IN.write) begin
                            next_st.prio_mask = REQ_IN.wdata[7:0] & PRIO_KEEP;
                        end else begin
                            next_st.rdata[7:0] = st.prio_mask;
                        end
                    end
                endcase
            end
        end
        // A falling enable pushes a one-of-N interrupt of that security state elsewhere.
        if (PEND_IN.valid && PEND_IN.group1 && PEND_IN.one_of_n
            && ((PEND_IN.secure && st.secure_group1_enable && !next_st.secure_group1_enable)
            || (!PEND_IN.secure && st.nonsecure_group1_enable
            && !next_st.nonsecure_group1_enable))) begin
            next_st.retarget = 1'b1;
            next_st.retarget_id = PEND_IN.id;
        end
        // Signalling looks at the next values so a mask write or an ack is never late.
        next_st.signal = PEND_IN.valid && PEND_IN.group1
            && (PEND_IN.secure ? next_st.secure_group1_enable
            : next_st.nonsecure_group1_enable)
            && (PEND_IN.prio < next_st.prio_mask)
            && !(next_st.acked && PEND_IN.id == next_st.acked_id);
    end

    // State register; only the stored fields have meaningful reset values.
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            st <= '0;
            st.secure_group1_enable <= cig_pkg::CIG_GRP1_RESET;
            st.nonsecure_group1_enable <= cig_pkg::CIG_GRP1_RESET;
            st.prio_mask <= cig_pkg::CIG_PRIO_MASK_RESET;
        end else begin
            st <= next_st;
        end
    end

    // The identifier width is a fixed property, still presented from a flop.
    logic [2:0] id_width;
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            id_width <= 3'h0;
        end else begin
            id_width <= ID_CODE;
        end
    end

    // Outputs taken straight from the state register, and the width field from its own flop.
    assign DONE_OUT = st.done;
    assign RDATA_OUT = st.rdata;
    assign UNDEF_OUT = st.undef;
    assign TRAP_OUT = st.trap;
    assign TRAP_EL_OUT = st.trap_el;
    assign SYNDROME_OUT = st.syndrome;
    assign ACK_OUT = st.ack;
    assign ACK_ID_OUT = st.ack_id;
    assign RETARGET_OUT = st.retarget;
    assign RETARGET_ID_OUT = st.retarget_id;
    assign IRQ_SIGNAL_OUT = st.signal;
    assign ID_WIDTH_FIELD_OUT = id_width;

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);

    // A good acknowledge is a read taken and then answered with an ack pulse.
    sequence s_ack_taken;
        REQ_IN.valid && !REQ_IN.write && REQ_IN.sel == cig_pkg::CIG_SEL_NMI_ACK_G1
            && !undef_c && !trap_c && !use_virtual && ack_ok;
    endsequence
    sequence s_ack_answered;
        ##1 ACK_OUT && DONE_OUT && RDATA_OUT[23:0] == ACK_ID_OUT;
    endsequence

    a_el3_low_undef: assert property (
        REQ_IN.valid && REQ_IN.sel == cig_pkg::CIG_SEL_GRP1_EN_EL3
        && REQ_IN.el != cig_pkg::CIG_EL3 |=> UNDEF_OUT && !TRAP_OUT)
        else $error("EL3 enable access below EL3 was not undefined.");
    a_el3_trap_class: assert property (
        REQ_IN.valid && REQ_IN.sel == cig_pkg::CIG_SEL_GRP1_EN_EL3
        && REQ_IN.el == cig_pkg::CIG_EL3 && !CTL_IN.sysreg_if_enable_el3
        |=> TRAP_OUT && SYNDROME_OUT == 6'h18 && TRAP_EL_OUT == 2'h3)
        else $error("Disabled EL3 enable access did not trap with class 0x18.");
    a_enable_write_bits: assert property (
        REQ_IN.valid && REQ_IN.write && !undef_c && !trap_c
        && REQ_IN.sel == cig_pkg::CIG_SEL_GRP1_EN_EL3
        |=> st.secure_group1_enable == $past(REQ_IN.wdata[1])
        && st.nonsecure_group1_enable == $past(REQ_IN.wdata[0]))
        else $error("Enable register write did not land in bits 1 and 0.");
    a_alias_secure_view: assert property (
        REQ_IN.valid && REQ_IN.write && !undef_c && !trap_c
        && REQ_IN.sel == cig_pkg::CIG_SEL_GRP1_EN_EL1 && REQ_IN.secure
        |=> st.secure_group1_enable == $past(REQ_IN.wdata[0])
        && $stable(st.nonsecure_group1_enable))
        else $error("Secure EL1 view did not alias the Secure enable bit.");
    a_alias_nonsec_view: assert property (
        REQ_IN.valid && REQ_IN.write && !undef_c && !trap_c
        && REQ_IN.sel == cig_pkg::CIG_SEL_GRP1_EN_EL1 && !REQ_IN.secure
        |=> st.nonsecure_group1_enable == $past(REQ_IN.wdata[0])
        && $stable(st.secure_group1_enable))
        else $error("Non-secure EL1 view did not alias the Non-secure enable bit.");
    // Both security states retarget, and the pulse must name the interrupt that was pending.
    a_retarget_on_fall: assert property (
        $fell(st.nonsecure_group1_enable)
        && $past(PEND_IN.valid && PEND_IN.group1 && PEND_IN.one_of_n && !PEND_IN.secure)
        |-> RETARGET_OUT && RETARGET_ID_OUT == $past(PEND_IN.id))
        else $error("Falling enable did not retarget the pending interrupt.");
    a_retarget_secure: assert property (
        $fell(st.secure_group1_enable)
        && $past(PEND_IN.valid && PEND_IN.group1 && PEND_IN.one_of_n && PEND_IN.secure)
        |-> RETARGET_OUT && RETARGET_ID_OUT == $past(PEND_IN.id))
        else $error("Falling Secure enable did not retarget the pending interrupt.");
    // Looks one edge past a sampled reset, so the very first edge never sees unset state.
    a_reset_clears: assert property (@(posedge CLOCK_IN) disable iff (1'b0)
        RST_IN |=> !st.secure_group1_enable && !st.nonsecure_group1_enable
        && st.prio_mask == 8'h00 && !IRQ_SIGNAL_OUT && !DONE_OUT)
        else $error("Reset left an enable or the mask set.");
    a_ack_read_id: assert property (s_ack_taken |-> s_ack_answered)
        else $error("Acknowledge read did not activate and return the identifier.");
    a_ack_spurious: assert property (
        REQ_IN.valid && !REQ_IN.write && !undef_c && !trap_c
        && REQ_IN.sel == cig_pkg::CIG_SEL_NMI_ACK_G1 && !use_virtual && !ack_ok
        |=> RDATA_OUT[23:0] == 24'h0003FF && !ACK_OUT)
        else $error("Unobservable acknowledge did not return the special identifier.");
    a_id_width_zero: assert property (
        ID_BITS == 16 |-> RDATA_OUT[23:16] == 8'h00
        || !$past(REQ_IN.sel == cig_pkg::CIG_SEL_NMI_ACK_G1))
        else $error("Unimplemented identifier bits were not zero.");
    a_ack_no_spurious: assert property (ACK_OUT |-> !IRQ_SIGNAL_OUT)
        else $error("Interrupt still signalled in the cycle after its acknowledge.");
    a_nmi_off_undef: assert property (
        REQ_IN.valid && REQ_IN.el == cig_pkg::CIG_EL1
        && REQ_IN.sel == cig_pkg::CIG_SEL_NMI_ACK_G1 && !CTL_IN.nmi_feature_enable
        |=> UNDEF_OUT && !ACK_OUT)
        else $error("NMI ack at EL1 with the feature off was not undefined.");
    a_virtual_ack: assert property (
        REQ_IN.valid && !undef_c && !trap_c && use_virtual
        && REQ_IN.sel == cig_pkg::CIG_SEL_NMI_ACK_G1 |=> !ACK_OUT
        && RDATA_OUT[23:0] == ($past(VIRTUAL_NMI_ACK_GROUP1_IN) & ID_KEEP))
        else $error("Routed EL1 acknowledge did not return the virtual value.");
    a_mask_filters: assert property (
        IRQ_SIGNAL_OUT |-> $past(PEND_IN.prio) < st.prio_mask)
        else $error("Interrupt signalled at or below the priority mask.");
    a_mask_write_now: assert property (
        REQ_IN.valid && REQ_IN.write && !undef_c && !trap_c
        && REQ_IN.sel == cig_pkg::CIG_SEL_PRIO_MASK
        && PEND_IN.prio >= (REQ_IN.wdata[7:0] & PRIO_KEEP) |=> !IRQ_SIGNAL_OUT)
        else $error("Interrupt signalled after a mask write that blocks it.");
    a_mask_low_zero: assert property ((st.prio_mask & ~PRIO_KEEP) == 8'h00)
        else $error("Unimplemented priority bits are not zero.");
    a_mask_32_view: assert property (
        REQ_IN.valid && !REQ_IN.write && !undef_c && !trap_c
        && REQ_IN.sel == cig_pkg::CIG_SEL_PRIO_MASK_32
        |=> RDATA_OUT[7:0] == $past(st.prio_mask))
        else $error("32-bit mask view does not show the shared storage.");

endmodule : cig_cpu_if

// ==== core/cig_pkg.sv ====
// Constants, encodings and carrier types for the group-one enable, NMI ack and priority mask block.
package cig_pkg;

    // Register selects carried by a system register access.
    typedef enum logic [2:0] {
        CIG_SEL_GRP1_EN_EL3 = 3'h0,
        CIG_SEL_GRP1_EN_EL1 = 3'h1,
        CIG_SEL_NMI_ACK_G1 = 3'h2,
        CIG_SEL_PRIO_MASK = 3'h3,
        CIG_SEL_PRIO_MASK_32 = 3'h4
    } cig_sel_t;

    // Field positions of the group-one enable register.
    localparam int CIG_GRP1_NS_BIT = 0;
    localparam int CIG_GRP1_S_BIT = 1;
    // Field widths of the identifier and priority fields.
    localparam int CIG_ID_FIELD_W = 24;
    localparam int CIG_PRIO_FIELD_W = 8;
    // Reset values of the stored fields.
    localparam logic CIG_GRP1_RESET = 1'h0;
    localparam logic [7:0] CIG_PRIO_MASK_RESET = 8'h00;
    // Trap syndrome class and the trap target levels.
    localparam logic [5:0] CIG_TRAP_SYNDROME = 6'h18;
    localparam logic [1:0] CIG_EL0 = 2'h0;
    localparam logic [1:0] CIG_EL1 = 2'h1;
    localparam logic [1:0] CIG_EL3 = 2'h3;
    // Special identifier returned when no interrupt can be acknowledged.
    localparam logic [23:0] CIG_SPURIOUS_ID = 24'h0003FF;
    // Identifier width field codes and field masks.
    localparam logic [2:0] CIG_ID_WIDTH_16 = 3'h0;
    localparam logic [2:0] CIG_ID_WIDTH_24 = 3'h1;
    localparam logic [23:0] CIG_ID_MASK_16 = 24'h00FFFF;
    localparam logic [23:0] CIG_ID_MASK_24 = 24'hFFFFFF;

    // One system register access from the core.
    typedef struct packed {
        logic valid;
        logic write;
        cig_sel_t sel;
        logic [1:0] el;
        logic secure;
        logic [63:0] wdata;
    } cig_req_t;

    // Core-side control levels that steer access checks.
    typedef struct packed {
        logic sysreg_if_enable_el3;
        logic sysreg_if_enable_cur;
        logic nmi_feature_enable;
        logic el2_enabled;
        logic irq_route_to_hyp;
    } cig_ctl_t;

    // Highest-priority pending interrupt offered to this processing element.
    typedef struct packed {
        logic valid;
        logic [23:0] id;
        logic [7:0] prio;
        logic group1;
        logic secure;
        logic nmi;
        logic one_of_n;
    } cig_pend_t;

    // State of the block, apart from the identifier width flop.
    typedef struct packed {
        logic secure_group1_enable;
        logic nonsecure_group1_enable;
        logic [7:0] prio_mask;
        logic acked;
        logic [23:0] acked_id;
        logic done;
        logic [63:0] rdata;
        logic undef;
        logic trap;
        logic [1:0] trap_el;
        logic [5:0] syndrome;
        logic ack;
        logic [23:0] ack_id;
        logic retarget;
        logic [23:0] retarget_id;
        logic signal;
    } cig_state_t;

endpackage : cig_pkg

// ==== tb/cig_core_model.sv ====
// Processor core model that issues system register accesses one at a time.
`timescale 1ns/100ps
module cig_core_model (
    input wire logic clock_in,
    output cig_pkg::cig_req_t req_out
);
    initial req_out = '0;

    // Presents an access after an edge and keeps it for exactly the edge that takes it.
    // The data field is scrambled afterwards so that stale write data is never trusted.
    task automatic access(input logic wr, input cig_pkg::cig_sel_t sel, input logic [1:0] el,
                          input logic sec, input logic [63:0] wd);
        @(posedge clock_in);
        req_out <= '{valid: 1'h1, write: wr, sel: sel, el: el, secure: sec, wdata: wd};
        @(posedge clock_in);
        req_out.valid <= 1'h0;
        req_out.wdata <= ~wd;
        #1;
    endtask : access
endmodule : cig_core_model

// ==== tb/test_cig_cpu_if.sv ====
// Self-checking bench for the group-one enable, NMI acknowledge and priority mask block.
`timescale 1ns/100ps
module test_cig_cpu_if;
    localparam int prio_bits = 5;
    localparam logic [7:0] pmask = 8'hF8;
    localparam cig_pkg::cig_sel_t s_en3 = cig_pkg::CIG_SEL_GRP1_EN_EL3;
    localparam cig_pkg::cig_sel_t s_en1 = cig_pkg::CIG_SEL_GRP1_EN_EL1;
    localparam cig_pkg::cig_sel_t s_nmi = cig_pkg::CIG_SEL_NMI_ACK_G1;
    localparam cig_pkg::cig_sel_t s_pm = cig_pkg::CIG_SEL_PRIO_MASK;
    localparam cig_pkg::cig_sel_t s_pm32 = cig_pkg::CIG_SEL_PRIO_MASK_32;
    logic clock_in = 1'h0;
    logic rst_in = 1'h1;
    cig_pkg::cig_req_t req;
    cig_pkg::cig_ctl_t ctl = 5'h1C;
    cig_pkg::cig_pend_t pend = '0;
    cig_pkg::cig_pend_t p;
    logic [23:0] vack = 24'hA5C3;
    logic done, undef, trap, ack, rt, irq;
    logic [63:0] rdata;
    logic [1:0] trap_el;
    logic [5:0] syn;
    logic [23:0] ack_id, rt_id;
    logic [2:0] idw;
    logic m_s = 1'h0;
    logic m_ns = 1'h0;
    logic sup = 1'h0;
    int rt_count = 0;
    int rt_base = 0;
    logic [7:0] m_mask = 8'h00;
    logic [63:0] wd;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 32'hDD01;

    cig_core_model core_u (.clock_in(clock_in), .req_out(req));
    cig_cpu_if #(.PRIO_BITS(prio_bits), .ID_BITS(24)) dut_u (
        .CLOCK_IN(clock_in), .RST_IN(rst_in), .REQ_IN(req), .CTL_IN(ctl), .PEND_IN(pend),
        .VIRTUAL_NMI_ACK_GROUP1_IN(vack), .DONE_OUT(done), .RDATA_OUT(rdata),
        .UNDEF_OUT(undef), .TRAP_OUT(trap), .TRAP_EL_OUT(trap_el), .SYNDROME_OUT(syn),
        .ACK_OUT(ack), .ACK_ID_OUT(ack_id), .RETARGET_OUT(rt), .RETARGET_ID_OUT(rt_id),
        .IRQ_SIGNAL_OUT(irq), .ID_WIDTH_FIELD_OUT(idw));

    // A 25 ns clock.
    initial forever #12.5 clock_in = ~clock_in;

    // Retarget is a one-cycle pulse, so pulses are counted here and judged later.
    always @(posedge clock_in) if (rt === 1'h1) rt_count <= rt_count + 1;

    // Cuts a hang short; the whole run needs well under two thousand cycles.
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Reference signalling: smaller value wins, and an acked id stays quiet until it changes.
    function automatic logic exp_irq();
        return pend.valid && pend.group1 && (pend.secure ? m_s : m_ns) && pend.prio < m_mask
            && !sup;
    endfunction : exp_irq

    // One access; answer class is {done, undef, trap}, and the signal line is compared too.
    task automatic acc(input logic wr, input cig_pkg::cig_sel_t sel, input logic [1:0] el,
                       input logic sec, input logic [63:0] d, input logic [2:0] cls,
                       input logic [63:0] rd);
        core_u.access(wr, sel, el, sec, d);
        check({done, undef, trap}, cls);
        check(rdata, rd);
        check(irq, exp_irq());
    endtask : acc

    task automatic set_pend(input cig_pkg::cig_pend_t np);
        sup = sup && np.valid && (np.id == pend.id);
        @(posedge clock_in);
        pend <= np;
        @(posedge clock_in);
        #1;
        check(irq, exp_irq());
    endtask : set_pend

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // Main sequence.
    initial begin
        repeat (5) @(posedge clock_in);
        rst_in <= 1'h0;
        acc(1'h0, s_en3, 2'h3, 1'h0, '0, 3'h4, '0);
        acc(1'h0, s_pm, 2'h1, 1'h0, '0, 3'h4, '0);
        check(idw, cig_pkg::CIG_ID_WIDTH_24);
        $display("test reset done");
        m_mask = pmask;
        acc(1'h1, s_pm, 2'h1, 1'h0, 64'hFF, 3'h4, '0);
        for (int i = 0; i < 8; i++) begin
            set_pend('{1'h1, {16'h1, i[7:0]}, 8'h10, 1'h1, i[0], 1'h0, 1'h0});
            wd = {$random(seed), $random(seed)};
            m_s = wd[1];
            m_ns = wd[0];
            acc(1'h1, s_en3, 2'h3, 1'h0, wd, 3'h4, '0);
            acc(1'h0, s_en3, 2'h3, 1'h0, '0, 3'h4, {62'h0, m_s, m_ns});
            m_s = ~m_s;
            acc(1'h1, s_en1, 2'h1, 1'h1, {63'h0, m_s}, 3'h4, '0);
            acc(1'h0, s_en1, 2'h1, 1'h1, '0, 3'h4, {63'h0, m_s});
            acc(1'h0, s_en1, 2'h1, 1'h0, '0, 3'h4, {63'h0, m_ns});
        end
        $display("test enables done");
        for (int e = 0; e < 3; e++) acc(1'h1, s_en3, e[1:0], 1'h0, 64'h3, 3'h6, '0);
        @(posedge clock_in);
        ctl.sysreg_if_enable_el3 <= 1'h0;
        acc(1'h1, s_en3, 2'h3, 1'h0, 64'h3, 3'h5, '0);
        check({trap_el, syn}, {2'h3, 6'h18});
        @(posedge clock_in);
        ctl.sysreg_if_enable_el3 <= 1'h1;
        acc(1'h0, s_en3, 2'h3, 1'h0, '0, 3'h4, {62'h0, m_s, m_ns});
        $display("test refusals done");
        m_s = 1'h1;
        m_ns = 1'h1;
        acc(1'h1, s_en3, 2'h3, 1'h0, 64'h3, 3'h4, '0);
        for (int i = 0; i < 12; i++) begin
            wd = {$random(seed), $random(seed)};
            set_pend('{1'h1, {16'h2, i[7:0]}, i[0] ? wd[15:8] : wd[7:0] & pmask,
                       1'h1, i[1], 1'h0, 1'h0});
            m_mask = wd[7:0] & pmask;
            acc(1'h1, i[2] ? s_pm32 : s_pm, 2'h1, i[1], wd, 3'h4, '0);
            acc(1'h0, i[2] ? s_pm : s_pm32, 2'h2, i[1], '0, 3'h4, {56'h0, m_mask});
        end
        $display("test mask done");
        m_mask = 8'h80;
        acc(1'h1, s_pm, 2'h1, 1'h0, 64'h80, 3'h4, '0);
        wd = {$random(seed), $random(seed)};
        p = '{1'h1, wd[23:0], 8'h20, 1'h1, 1'h0, 1'h1, 1'h0};
        set_pend(p);
        sup = 1'h1;
        acc(1'h0, s_nmi, 2'h1, 1'h0, '0, 3'h4, {40'h0, p.id});
        check({ack, ack_id}, {1'h1, p.id});
        acc(1'h0, s_nmi, 2'h1, 1'h0, '0, 3'h4, {40'h0, cig_pkg::CIG_SPURIOUS_ID});
        check(ack, 1'h0);
        p.nmi = 1'h0;
        p.id = p.id + 24'h1;
        set_pend(p);
        acc(1'h0, s_nmi, 2'h1, 1'h0, '0, 3'h4, {40'h0, cig_pkg::CIG_SPURIOUS_ID});
        @(posedge clock_in);
        ctl.nmi_feature_enable <= 1'h0;
        acc(1'h0, s_nmi, 2'h1, 1'h0, '0, 3'h6, '0);
        @(posedge clock_in);
        ctl <= 5'h1F;
        acc(1'h0, s_nmi, 2'h1, 1'h0, '0, 3'h4, {40'h0, vack});
        check(ack, 1'h0);
        $display("test acknowledge done");
        @(posedge clock_in);
        ctl <= 5'h1C;
        p.one_of_n = 1'h1;
        p.id = p.id + 24'h1;
        set_pend(p);
        rt_base = rt_count;
        m_ns = 1'h0;
        acc(1'h1, s_en3, 2'h3, 1'h0, {62'h0, m_s, 1'h0}, 3'h4, '0);
        repeat (3) @(posedge clock_in);
        #1;
        check({rt_count - rt_base, rt_id}, {32'h1, p.id});
        $display("test retarget done");
        // A warm reset in mid-run must clear the Secure enable and the mask set above.
        @(posedge clock_in);
        rst_in <= 1'h1;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'h0;
        m_s = 1'h0;
        m_ns = 1'h0;
        m_mask = 8'h00;
        sup = 1'h0;
        acc(1'h0, s_en3, 2'h3, 1'h0, '0, 3'h4, '0);
        acc(1'h0, s_pm32, 2'h1, 1'h0, '0, 3'h4, '0);
        check(idw, cig_pkg::CIG_ID_WIDTH_24);
        $display("test warm reset done");
        print_verdict();
    end
endmodule : test_cig_cpu_if
